// ===== acl_full_key_builder.sv
// Contract
// - OAM key holds opcode at 154, flags at 162, endpoint identifier at 170.
// - OAM bit 186 set when all three loss counters are zero.
// - OAM bit 187 set only for EtherType 0x8902.
// - Wide key bits 1:0 give key type: 0 transport, 1 generic, 2 custom.
// - Wide key bit 2 high on first lookup, low on second.
// - Eight-bit policy group at bit 3 from first-stage classification.
// - Twelve-bit one-hot ingress port mask at bit 11.
// - Bit 24 carries the source host binding lookup hit.
// - Bit 25 set when destination MAC bit 40 is one.
// - Bit 26 set for the all-ones broadcast destination.
// - Bit 27 set when frame has any Q-tag, regardless of port awareness.
// - Classified VID at 28, DEI at 40, PCP at 41.
// - Bit 44 set when hop limit is above zero.
// - Traffic class 45, destination 53, source 181, bit 309 addresses equal.
// - Bit 310 set when next header is six, clear for UDP.
// - Destination port 311, source port 327, bit 351 ports equal.
// - Eight range-checker hit bits at 343.
// - Range checkers test ports from frame, VID and DSCP from classification.
// - Bit 352 is TCP sequence zero, or PTP messageType bit 0.
// - Bits 353-358 are TCP flags, or PTP message and flag bits.
// - PTP domain number at 359, version at 367.
// - OAM level is a seven-bit thermometer code.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module acl_full_key_builder #(
	parameter int RANGES = key_builder_pkg::RANGE_COUNT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frame_valid,
	output logic frame_ready,
	input wire logic [47:0] dest_mac,
	input wire logic [47:0] src_mac,
	input wire logic [15:0] ether_type,
	input wire logic [1:0] qtag_count,
	input wire logic [3:0] ingress_port,
	input wire logic [7:0] policy_group,
	input wire logic host_bind_v4_lookup,
	input wire logic host_bind_v6_lookup,
	input wire logic [11:0] cls_vid,
	input wire logic cls_dei,
	input wire logic [2:0] cls_pcp,
	input wire logic [5:0] cls_dscp,
	input wire logic [7:0] hop_limit,
	input wire logic [7:0] traffic_class,
	input wire logic [127:0] v6_dest_addr,
	input wire logic [127:0] v6_src_addr,
	input wire logic [7:0] next_header,
	input wire logic [15:0] dest_port_field,
	input wire logic [15:0] src_port_field,
	input wire logic [31:0] tcp_seq_num,
	input wire logic [5:0] tcp_flag_bits,
	input wire logic is_ptp_udp,
	input wire logic [3:0] ptp_msg_type,
	input wire logic [7:0] ptp_flag_low,
	input wire logic [7:0] ptp_domain_field,
	input wire logic [3:0] ptp_version_field,
	input wire logic [2:0] oam_level,
	input wire logic [4:0] oam_version,
	input wire logic [7:0] oam_op_code_field,
	input wire logic [7:0] oam_flag_byte,
	input wire logic [15:0] oam_endpoint_ident,
	input wire logic [31:0] loss_fwd_tx,
	input wire logic [31:0] loss_bwd_rx,
	input wire logic [31:0] loss_bwd_tx,
	output logic key_valid,
	output logic key_first,
	output logic [key_builder_pkg::WIDE_KEY_W-1:0] wide_key,
	output logic [key_builder_pkg::OAM_KEY_W-1:0] oam_key
);

	key_builder_pkg::build_state_t state_reg;
	logic [2:0] ctrl_reg;
	logic [31:0] frames_reg;
	logic [RANGES-1:0] last_range_reg;
	logic [2:0] range_kind_reg [RANGES];
	logic [31:0] range_bound_reg [RANGES];

	// Captured frame fields, held for both lookups of the frame.
	logic [47:0] dmac_q, smac_q;
	logic [15:0] etype_q, dport_q, sport_q, endpoint_q;
	logic [1:0] qtags_q;
	logic [3:0] port_q, ptp_msg_q, ptp_ver_q;
	logic [7:0] policy_q, hop_q, tclass_q, proto_q, ptp_flag_q, ptp_dom_q, opcode_q, oflags_q;
	logic host_q, dei_q, ptp_q, seq_zero_q, loss_zero_q;
	logic [11:0] vid_q;
	logic [2:0] pcp_q, level_q;
	logic [5:0] dscp_q, tflags_q;
	logic [127:0] dip_q, sip_q;
	logic [4:0] over_q;

	logic [RANGES-1:0] range_hit;
	logic [key_builder_pkg::WIDE_KEY_W-1:0] wide_next;
	logic [key_builder_pkg::OAM_KEY_W-1:0] oam_next;
	logic accept;

	assign frame_ready = (state_reg == key_builder_pkg::ST_IDLE);
	assign accept = frame_valid && frame_ready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= key_builder_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				key_builder_pkg::ST_IDLE: begin
					if (frame_valid) begin
						state_reg <= key_builder_pkg::ST_FIRST;
					end
				end
				key_builder_pkg::ST_FIRST: state_reg <= key_builder_pkg::ST_SECOND;
				key_builder_pkg::ST_SECOND: state_reg <= key_builder_pkg::ST_IDLE;
				default: state_reg <= key_builder_pkg::ST_IDLE;
			endcase
		end
	end

	// Frame fields need no reset: they are only looked at while a key is built.
	always_ff @(posedge aclk) begin
		if (accept) begin
			dmac_q <= dest_mac;
			smac_q <= src_mac;
			etype_q <= ether_type;
			qtags_q <= qtag_count;
			port_q <= ingress_port;
			policy_q <= policy_group;
			host_q <= host_bind_v4_lookup | host_bind_v6_lookup;
			vid_q <= cls_vid;
			dei_q <= cls_dei;
			pcp_q <= cls_pcp;
			dscp_q <= cls_dscp;
			hop_q <= hop_limit;
			tclass_q <= traffic_class;
			dip_q <= v6_dest_addr;
			sip_q <= v6_src_addr;
			proto_q <= next_header;
			dport_q <= dest_port_field;
			sport_q <= src_port_field;
			seq_zero_q <= (tcp_seq_num == 32'h0000_0000);
			tflags_q <= tcp_flag_bits;
			ptp_q <= is_ptp_udp;
			ptp_msg_q <= ptp_msg_type;
			ptp_flag_q <= ptp_flag_low;
			ptp_dom_q <= ptp_domain_field;
			ptp_ver_q <= ptp_version_field;
			level_q <= oam_level;
			over_q <= oam_version;
			opcode_q <= oam_op_code_field;
			oflags_q <= oam_flag_byte;
			endpoint_q <= oam_endpoint_ident;
			loss_zero_q <= (loss_fwd_tx == 32'h0000_0000) && (loss_bwd_rx == 32'h0000_0000) &&
				(loss_bwd_tx == 32'h0000_0000);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < RANGES; gi++) begin : g_range
			logic [15:0] lo, hi;
			logic sport_in, dport_in;
			assign lo = range_bound_reg[gi][15:0];
			assign hi = range_bound_reg[gi][31:16];
			assign sport_in = (sport_q >= lo) && (sport_q <= hi);
			assign dport_in = (dport_q >= lo) && (dport_q <= hi);
			always_comb begin
				case (range_kind_reg[gi])
					key_builder_pkg::RNG_SPORT: range_hit[gi] = sport_in;
					key_builder_pkg::RNG_DPORT: range_hit[gi] = dport_in;
					key_builder_pkg::RNG_EITHER: range_hit[gi] = sport_in || dport_in;
					key_builder_pkg::RNG_VID: range_hit[gi] = ({4'h0, vid_q} >= lo) && ({4'h0, vid_q} <= hi);
					key_builder_pkg::RNG_DSCP: range_hit[gi] = ({10'h000, dscp_q} >= lo) && ({10'h000, dscp_q} <= hi);
					default: range_hit[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_comb begin
		wide_next = '0;
		wide_next[key_builder_pkg::TYPE_POS +: 2] = ctrl_reg[1:0];
		wide_next[key_builder_pkg::FIRST_POS] = (state_reg == key_builder_pkg::ST_FIRST);
		wide_next[key_builder_pkg::POLICY_POS +: 8] = policy_q;
		wide_next[key_builder_pkg::INGRESS_POS +: key_builder_pkg::PORT_COUNT] =
			key_builder_pkg::PORT_COUNT'(1) << port_q;
		// The reserved bit stays zero; entries must mask it anyway.
		wide_next[key_builder_pkg::HOST_POS] = host_q;
		wide_next[key_builder_pkg::MCAST_POS] = dmac_q[key_builder_pkg::DMAC_GROUP_BIT];
		wide_next[key_builder_pkg::BCAST_POS] = &dmac_q;
		wide_next[key_builder_pkg::QTAG_POS] = (qtags_q != 2'b00);
		wide_next[key_builder_pkg::VID_POS +: 12] = vid_q;
		wide_next[key_builder_pkg::DEI_POS] = dei_q;
		wide_next[key_builder_pkg::PCP_POS +: 3] = pcp_q;
		// Only the transport body is built here; other types leave their body at zero.
		if (ctrl_reg[1:0] == key_builder_pkg::V6_TRANSPORT) begin
			wide_next[key_builder_pkg::HOP_POS] = (hop_q != 8'h00);
			wide_next[key_builder_pkg::TCLASS_POS +: 8] = tclass_q;
			wide_next[key_builder_pkg::DIP_POS +: 128] = dip_q;
			wide_next[key_builder_pkg::SIP_POS +: 128] = sip_q;
			wide_next[key_builder_pkg::ADDR_EQ_POS] = (dip_q == sip_q);
			wide_next[key_builder_pkg::TCP_POS] = (proto_q == key_builder_pkg::PROTO_TCP);
			wide_next[key_builder_pkg::DPORT_POS +: 16] = dport_q;
			wide_next[key_builder_pkg::SPORT_POS +: 16] = sport_q;
			wide_next[key_builder_pkg::RANGE_POS +: RANGES] = range_hit;
			wide_next[key_builder_pkg::PORTS_EQ_POS] = (sport_q == dport_q);
			if (proto_q == key_builder_pkg::PROTO_TCP) begin
				wide_next[key_builder_pkg::SEQ_POS] = seq_zero_q;
				wide_next[key_builder_pkg::L4FLAGS_POS +: 6] = tflags_q;
			end else if (ptp_q) begin
				wide_next[key_builder_pkg::SEQ_POS] = ptp_msg_q[0];
				wide_next[key_builder_pkg::L4FLAGS_POS +: 6] =
					{ptp_flag_q[7], ptp_flag_q[2], ptp_flag_q[1], ptp_msg_q[3:1]};
				wide_next[key_builder_pkg::DOMAIN_POS +: 8] = ptp_dom_q;
				wide_next[key_builder_pkg::PTPVER_POS +: 4] = ptp_ver_q;
			end
		end
	end

	always_comb begin
		oam_next = '0;
		oam_next[key_builder_pkg::OAM_DMAC_POS +: 48] = dmac_q;
		oam_next[key_builder_pkg::OAM_SMAC_POS +: 48] = smac_q;
		oam_next[key_builder_pkg::OAM_LEVEL_POS +: key_builder_pkg::OAM_LEVEL_W] =
			key_builder_pkg::OAM_LEVEL_W'((8'h01 << level_q) - 8'h01);
		oam_next[key_builder_pkg::OAM_VER_POS +: 5] = over_q;
		oam_next[key_builder_pkg::OAM_OP_CODE_FIELD_POS +: 8] = opcode_q;
		oam_next[key_builder_pkg::OAM_FLAG_BYTE_POS +: 8] = oflags_q;
		oam_next[key_builder_pkg::OAM_ENDPOINT_POS +: 16] = endpoint_q;
		oam_next[key_builder_pkg::OAM_LOSS_ZERO_POS] = loss_zero_q;
		oam_next[key_builder_pkg::OAM_ETYPE_HIT_POS] = (etype_q == key_builder_pkg::OAM_ETHERTYPE);
	end

	// Keys are registered so the match table sees a clean, complete word each lookup.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_valid <= 1'b0;
			key_first <= 1'b0;
			wide_key <= '0;
			oam_key <= '0;
		end else begin
			key_valid <= (state_reg != key_builder_pkg::ST_IDLE);
			key_first <= (state_reg == key_builder_pkg::ST_FIRST);
			if (state_reg != key_builder_pkg::ST_IDLE) begin
				wide_key <= wide_next;
				oam_key <= oam_next;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frames_reg <= 32'h0000_0000;
			last_range_reg <= '0;
		end else if (state_reg == key_builder_pkg::ST_FIRST) begin
			frames_reg <= frames_reg + 32'h0000_0001;
			last_range_reg <= range_hit;
		end
	end

	// AXI4-Lite slave. Address and data are held independently and the write
	// is performed once both are present, so they may arrive in either order.
	logic aw_held, w_held;
	logic [11:0] aw_addr_q, ar_addr;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic wr_hit_kind, wr_hit_bound, rd_hit_kind, rd_hit_bound;
	localparam int RANGE_IDX_W_L = key_builder_pkg::RANGE_IDX_W;
	logic [RANGE_IDX_W_L-1:0] wr_idx, rd_idx;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = aw_addr_q[4:2];
	assign rd_idx = s_axi_araddr[4:2];
	assign ar_addr = s_axi_araddr;
	assign wr_hit_kind = ((aw_addr_q & key_builder_pkg::RANGE_BLOCK_MASK) == key_builder_pkg::RANGE_KIND_BASE);
	assign wr_hit_bound = ((aw_addr_q & key_builder_pkg::RANGE_BLOCK_MASK) == key_builder_pkg::RANGE_BOUND_BASE);
	assign rd_hit_kind = ((ar_addr & key_builder_pkg::RANGE_BLOCK_MASK) == key_builder_pkg::RANGE_KIND_BASE);
	assign rd_hit_bound = ((ar_addr & key_builder_pkg::RANGE_BLOCK_MASK) == key_builder_pkg::RANGE_BOUND_BASE);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= key_builder_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == key_builder_pkg::CTRL_ADDR || wr_hit_kind || wr_hit_bound) ?
				key_builder_pkg::RESP_OKAY : key_builder_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= key_builder_pkg::CTRL_RESET;
			for (int i = 0; i < RANGES; i++) begin
				range_kind_reg[i] <= key_builder_pkg::RNG_OFF;
				range_bound_reg[i] <= 32'h0000_0000;
			end
		end else if (do_write) begin
			if (aw_addr_q == key_builder_pkg::CTRL_ADDR && w_strb_q[0]) begin
				ctrl_reg <= w_data_q[2:0];
			end
			if (wr_hit_kind && w_strb_q[0]) begin
				range_kind_reg[wr_idx] <= w_data_q[2:0];
			end
			if (wr_hit_bound) begin
				range_bound_reg[wr_idx] <= merge(range_bound_reg[wr_idx], w_data_q, w_strb_q);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= key_builder_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= key_builder_pkg::RESP_OKAY;
			if (ar_addr == key_builder_pkg::CTRL_ADDR) begin
				s_axi_rdata <= {29'h0, ctrl_reg};
			end else if (ar_addr == key_builder_pkg::STATUS_ADDR) begin
				s_axi_rdata <= {22'h0, last_range_reg, state_reg};
			end else if (ar_addr == key_builder_pkg::FRAMES_ADDR) begin
				s_axi_rdata <= frames_reg;
			end else if (rd_hit_kind) begin
				s_axi_rdata <= {29'h0, range_kind_reg[rd_idx]};
			end else if (rd_hit_bound) begin
				s_axi_rdata <= range_bound_reg[rd_idx];
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= key_builder_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== acl_full_key_builder_bench.sv
`default_nettype none
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((e) !== (g)) begin \
		err_count++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module acl_full_key_builder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_valid, frame_ready, key_valid, key_first;
	logic host_bind_v4_lookup, host_bind_v6_lookup, cls_dei, is_ptp_udp, req_tgl, busy;
	logic [11:0] s_axi_awaddr, s_axi_araddr, cls_vid;
	logic [2:0] s_axi_awprot, s_axi_arprot, cls_pcp, oam_level;
	logic [31:0] s_axi_wdata, s_axi_rdata, tcp_seq_num, loss_fwd_tx, loss_bwd_rx, loss_bwd_tx;
	logic [3:0] s_axi_wstrb, ingress_port, ptp_msg_type, ptp_version_field;
	logic [1:0] s_axi_bresp, s_axi_rresp, qtag_count, lag, ktype;
	logic [47:0] dest_mac, src_mac;
	logic [15:0] ether_type, dest_port_field, src_port_field, oam_endpoint_ident;
	logic [7:0] policy_group, hop_limit, traffic_class, next_header, ptp_flag_low, ptp_domain_field;
	logic [7:0] oam_op_code_field, oam_flag_byte, last_hits;
	logic [5:0] cls_dscp, tcp_flag_bits;
	logic [4:0] oam_version;
	logic [127:0] v6_dest_addr, v6_src_addr;
	logic [key_builder_pkg::WIDE_KEY_W-1:0] wide_key, qw[$];
	logic [key_builder_pkg::OAM_KEY_W-1:0] oam_key, qo[$];
	logic want_first = 1'b1;
	int seed = 32'h0000_487f;
	int err_count = 0, n_tests = 0;
	int kinds[8] = '{0, 1, 2, 3, 4, 0, 7, 5};
	int rlo[8], rhi[8];
	acl_full_key_builder u_dut (.*);
	frame_offer u_src (.*);
	always #4 aclk = ~aclk;
	task automatic end_sim();
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic axi_wr(input logic [11:0] a, logic [31:0] d, logic [1:0] er = key_builder_pkg::RESP_OKAY);
		logic got = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				got = 1'b1;
				s_axi_bready <= 1'b0;
				`CHK("bresp", er, s_axi_bresp)
			end
		end
	endtask
	task automatic axi_rd(input logic [11:0] a, logic [31:0] ed, logic [1:0] er = key_builder_pkg::RESP_OKAY);
		logic got = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				got = 1'b1;
				s_axi_rready <= 1'b0;
				`CHK("rdata", ed, s_axi_rdata)
				`CHK("rresp", er, s_axi_rresp)
			end
		end
	endtask
	task automatic rand_fields();
		logic [31:0] c, e;
		logic [127:0] d;
		logic [15:0] p;
		c = $random(seed);
		e = $random(seed);
		d = {$random(seed), $random(seed), $random(seed), $random(seed)};
		p = 16'($random(seed)) & 16'h007f;
		dest_mac <= c[0] ? 48'hffff_ffff_ffff : 48'({$random(seed), $random(seed)});
		src_mac <= 48'({$random(seed), $random(seed)});
		ether_type <= c[1] ? 16'h8902 : 16'($random(seed));
		qtag_count <= c[3:2];
		ingress_port <= 4'(e[31:28] % 12);
		policy_group <= c[11:4];
		{host_bind_v4_lookup, host_bind_v6_lookup, cls_dei, is_ptp_udp} <= c[15:12];
		cls_vid <= 12'($random(seed)) & 12'h07f;
		cls_pcp <= c[18:16];
		cls_dscp <= e[5:0];
		hop_limit <= c[19] ? 8'h00 : 8'($random(seed));
		traffic_class <= c[27:20];
		v6_dest_addr <= d;
		v6_src_addr <= c[5] ? d : {$random(seed), $random(seed), $random(seed), $random(seed)};
		next_header <= c[6] ? 8'h06 : (c[7] ? 8'h11 : 8'($random(seed)));
		dest_port_field <= p;
		src_port_field <= c[8] ? p : 16'($random(seed)) & 16'h007f;
		tcp_seq_num <= c[9] ? 32'h0000_0000 : $random(seed);
		{tcp_flag_bits, ptp_msg_type, ptp_version_field, oam_level, oam_version} <= e[27:6];
		{ptp_flag_low, ptp_domain_field, oam_op_code_field, oam_flag_byte} <= $random(seed);
		oam_endpoint_ident <= 16'($random(seed));
		loss_fwd_tx <= c[10] ? 32'h0000_0000 : $random(seed);
		loss_bwd_rx <= c[10] ? 32'h0000_0000 : $random(seed);
		loss_bwd_tx <= c[24] ? 32'h0000_0000 : $random(seed);
	endtask
	function automatic bit inr(int i, int x);
		return x >= rlo[i] && x <= rhi[i];
	endfunction
	task automatic model();
		logic [key_builder_pkg::WIDE_KEY_W-1:0] w;
		logic [key_builder_pkg::OAM_KEY_W-1:0] o;
		for (int i = 0; i < 8; i++) begin
			last_hits[i] = kinds[i] == 0 ? inr(i, src_port_field) : kinds[i] == 1 ? inr(i, dest_port_field) :
				kinds[i] == 2 ? inr(i, src_port_field) || inr(i, dest_port_field) :
				kinds[i] == 3 ? inr(i, cls_vid) : kinds[i] == 4 ? inr(i, cls_dscp) : 1'b0;
		end
		w = '0;
		w[1:0] = ktype;
		w[10:3] = policy_group;
		w[11 + ingress_port] = 1'b1;
		w[27:24] = {qtag_count != 2'b00, &dest_mac, dest_mac[40], host_bind_v4_lookup | host_bind_v6_lookup};
		w[43:28] = {cls_pcp, cls_dei, cls_vid};
		if (ktype == 2'b00) begin
			w[52:44] = {traffic_class, hop_limit != 8'h00};
			w[308:53] = {v6_src_addr, v6_dest_addr};
			w[310:309] = {next_header == 8'h06, v6_src_addr == v6_dest_addr};
			w[351:311] = {src_port_field == dest_port_field, last_hits, src_port_field, dest_port_field};
			if (next_header == 8'h06) begin
				w[358:352] = {tcp_flag_bits, tcp_seq_num == 32'h0000_0000};
			end else if (is_ptp_udp) begin
				w[358:352] = {ptp_flag_low[7], ptp_flag_low[2:1], ptp_msg_type};
				w[370:359] = {ptp_version_field, ptp_domain_field};
			end
		end
		o = '0;
		o[141:46] = {src_mac, dest_mac};
		o[148:142] = 7'h7f >> (7 - oam_level);
		o[185:149] = {oam_endpoint_ident, oam_flag_byte, oam_op_code_field, oam_version};
		o[186] = (loss_fwd_tx | loss_bwd_rx | loss_bwd_tx) == 32'h0000_0000;
		o[187] = ether_type == 16'h8902;
		qw.push_back(w);
		qo.push_back(o);
	endtask
	// Fields change at the accepting edge, so with lag 0 the next offer first meets frame_ready low.
	task automatic send();
		do @(posedge aclk); while (busy && !(frame_valid && frame_ready));
		rand_fields();
		req_tgl <= ~req_tgl;
		lag <= 2'($random(seed));
		#1 model();
	endtask
	always @(negedge aclk) begin
		if (aresetn === 1'b1 && key_valid === 1'b1) begin
			`CHK("key_first", want_first, key_first)
			`CHK("wide_key", qw[0] | (371'(want_first) << 2), wide_key)
			`CHK("oam_key", qo[0], oam_key)
			if (!want_first) begin
				void'(qw.pop_front());
				void'(qo.pop_front());
			end
			want_first = !want_first;
		end
	end
	initial begin
		repeat (30000) @(posedge aclk);
		err_count++;
		end_sim();
	end
	initial begin
		aresetn <= 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req_tgl} <= 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 56'h0;
		{s_axi_awprot, s_axi_arprot, lag, ktype} <= 10'h000;
		s_axi_wstrb <= 4'hf;
		rand_fields();
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(key_builder_pkg::CTRL_ADDR, 32'h0000_0000);
		axi_rd(key_builder_pkg::FRAMES_ADDR, 32'h0000_0000);
		axi_rd(12'h100, 32'h0000_0000, key_builder_pkg::RESP_SLVERR);
		axi_wr(12'h100, 32'h0000_0001, key_builder_pkg::RESP_SLVERR);
		axi_wr(key_builder_pkg::STATUS_ADDR, 32'h0000_0001, key_builder_pkg::RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			logic [11:0] ka, ba;
			logic [31:0] bd;
			ka = key_builder_pkg::RANGE_KIND_BASE + 12'(4 * i);
			ba = key_builder_pkg::RANGE_BOUND_BASE + 12'(4 * i);
			axi_rd(ka, 32'h0000_0007);
			axi_rd(ba, 32'h0000_0000);
			rlo[i] = $random(seed) & 63;
			rhi[i] = rlo[i] + ($random(seed) & 63);
			bd = {16'(rhi[i]), 16'(rlo[i])};
			axi_wr(ka, 32'(kinds[i]));
			axi_wr(ba, bd);
			axi_rd(ba, bd);
		end
		for (int t = 0; t < 3; t++) begin
			ktype = 2'(t);
			axi_wr(key_builder_pkg::CTRL_ADDR, 32'(t));
			repeat (40) send();
			while (qw.size() != 0) @(posedge aclk);
			axi_rd(key_builder_pkg::STATUS_ADDR, {22'h0, last_hits, 2'b00});
		end
		axi_rd(key_builder_pkg::FRAMES_ADDR, 32'h0000_0078);
		end_sim();
	end
endmodule
`undef CHK
`default_nettype wire

// ===== frame_offer.sv
`default_nettype none
module frame_offer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_tgl,
	input wire logic [1:0] lag,
	input wire logic frame_ready,
	output logic frame_valid,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic seen;
	logic [1:0] cnt;
	// A request waits lag cycles, then valid holds until the builder takes it.
	assign busy = frame_valid || (req_tgl != seen);
	always @(posedge aclk) begin
		if (!aresetn) begin
			frame_valid <= 1'b0;
			seen <= 1'b0;
			cnt <= 2'b00;
		end else if (frame_valid) begin
			if (frame_ready) frame_valid <= 1'b0;
		end else if (req_tgl != seen) begin
			if (cnt >= lag) begin
				frame_valid <= 1'b1;
				seen <= req_tgl;
				cnt <= 2'b00;
			end else begin
				cnt <= cnt + 2'b01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== key_builder_pkg.sv
`default_nettype none
package key_builder_pkg;

	localparam int WIDE_KEY_W = 371;
	localparam int OAM_KEY_W = 188;
	localparam int PORT_COUNT = 12;
	localparam int PORT_IDX_W = 4;
	localparam int RANGE_COUNT = 8;
	localparam int RANGE_IDX_W = 3;

	// OAM key layout.
	localparam int OAM_DMAC_POS = 46;
	localparam int OAM_SMAC_POS = 94;
	localparam int OAM_LEVEL_POS = 142;
	localparam int OAM_LEVEL_W = 7;
	localparam int OAM_VER_POS = 149;
	localparam int OAM_OP_CODE_FIELD_POS = 154;
	localparam int OAM_FLAG_BYTE_POS = 162;
	localparam int OAM_ENDPOINT_POS = 170;
	localparam int OAM_LOSS_ZERO_POS = 186;
	localparam int OAM_ETYPE_HIT_POS = 187;
	localparam logic [15:0] OAM_ETHERTYPE = 16'h8902;

	// Common wide key layout.
	localparam int TYPE_POS = 0;
	localparam int FIRST_POS = 2;
	localparam int POLICY_POS = 3;
	localparam int INGRESS_POS = 11;
	localparam int HOST_POS = 24;
	localparam int MCAST_POS = 25;
	localparam int BCAST_POS = 26;
	localparam int QTAG_POS = 27;
	localparam int VID_POS = 28;
	localparam int DEI_POS = 40;
	localparam int PCP_POS = 41;
	localparam int DMAC_GROUP_BIT = 40;

	// Transport key layout.
	localparam int HOP_POS = 44;
	localparam int TCLASS_POS = 45;
	localparam int DIP_POS = 53;
	localparam int SIP_POS = 181;
	localparam int ADDR_EQ_POS = 309;
	localparam int TCP_POS = 310;
	localparam int DPORT_POS = 311;
	localparam int SPORT_POS = 327;
	localparam int RANGE_POS = 343;
	localparam int PORTS_EQ_POS = 351;
	localparam int SEQ_POS = 352;
	localparam int L4FLAGS_POS = 353;
	localparam int DOMAIN_POS = 359;
	localparam int PTPVER_POS = 367;
	localparam logic [7:0] PROTO_TCP = 8'h06;

	typedef enum logic [1:0] {
		V6_TRANSPORT = 2'b00,
		V6_GENERIC = 2'b01,
		CUSTOM_KEY = 2'b10
	} wide_key_type_t;

	typedef enum logic [2:0] {
		RNG_SPORT = 3'b000,
		RNG_DPORT = 3'b001,
		RNG_EITHER = 3'b010,
		RNG_VID = 3'b011,
		RNG_DSCP = 3'b100,
		RNG_OFF = 3'b111
	} range_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FIRST = 2'b01,
		ST_SECOND = 2'b10
	} build_state_t;

	// Register map (byte addresses).
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] FRAMES_ADDR = 12'h008;
	localparam logic [11:0] RANGE_KIND_BASE = 12'h020;
	localparam logic [11:0] RANGE_BOUND_BASE = 12'h040;
	localparam logic [11:0] RANGE_BLOCK_MASK = 12'hFE0;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// ===== key_checker.sv
`default_nettype none
module key_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire logic key_valid,
	input wire logic key_first,
	input wire logic [key_builder_pkg::WIDE_KEY_W-1:0] wide_key,
	input wire logic [key_builder_pkg::OAM_KEY_W-1:0] oam_key
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	take_to_key_a: assert property (frame_valid && frame_ready |-> ##2 key_valid && key_first)
		else $error("first key missing two cycles after accept");
	second_key_a: assert property (key_valid && key_first |=> key_valid && !key_first)
		else $error("second key does not follow first");
	first_bit_a: assert property (key_valid |-> wide_key[2] == key_first)
		else $error("lookup bit disagrees with key_first");
	ready_gap_a: assert property (frame_valid && frame_ready |=> !frame_ready [*2] ##1 frame_ready)
		else $error("frame_ready gap after accept wrong");
	onehot_port_a: assert property (key_valid |-> $onehot(wide_key[22:11]))
		else $error("ingress mask not one-hot");
	cast_flags_a: assert property (key_valid |-> wide_key[26] == &oam_key[93:46] && wide_key[25] == oam_key[86])
		else $error("multicast or broadcast flag wrong");
	addr_equal_a: assert property (key_valid && wide_key[1:0] == 2'b00
		|-> wide_key[309] == (wide_key[180:53] == wide_key[308:181]))
		else $error("address equality flag wrong");
	port_equal_a: assert property (key_valid && wide_key[1:0] == 2'b00
		|-> wide_key[351] == (wide_key[326:311] == wide_key[342:327]))
		else $error("port equality flag wrong");
	level_code_a: assert property (key_valid |-> (oam_key[148:142] & (oam_key[148:142] + 7'h01)) == 7'h00)
		else $error("level field not a thermometer code");
	oam_same_a: assert property (key_valid && key_first |=> $stable(oam_key))
		else $error("OAM key changed between lookups");
	reserved_low_a: assert property (key_valid |-> !wide_key[23])
		else $error("reserved key bit driven high");
	frame_taken_c: cover property (frame_valid && frame_ready);
	frame_refused_c: cover property (frame_valid && !frame_ready);
	second_key_c: cover property (key_valid && !key_first);
endmodule
bind acl_full_key_builder key_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .frame_valid(frame_valid), .frame_ready(frame_ready),
	.key_valid(key_valid), .key_first(key_first), .wide_key(wide_key), .oam_key(oam_key)
);
`default_nettype wire
